// File: rtl/fuse_decoder.sv
`timescale 1ns/1ps
`include "fuse_decoder_cfg.svh"

module device_config_fuse_decoder
    import fuse_decoder_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // nonvolatile byte load port
    input  wire logic        nv_valid,
    input  wire logic [2:0]  nv_index,
    input  wire logic [7:0]  nv_data,
    input  wire logic        nv_done,
    // runtime input from reset control
    input  wire logic        software_watchdog_enable,
    // decoded outputs
    output mem_ctl_t         mem_ctl,
    output clk_ctl_t         clk_ctl,
    output logic             config_ready
);

    // ==========================================================
    // state
    typedef struct packed {
        load_state_t               st;
        logic [`NUM_BYTES-1:0][7:0] bytes;
        logic [`NUM_BYTES-1:0]     written;
        logic                      wdt_forced;
        mem_ctl_t                  mem;
        clk_ctl_t                  clk;
        logic [31:0]               rdata;
    } state_t;

    state_t s;
    state_t next_s;

    // ==========================================================
    // decode helpers
    function automatic logic [23:0] boot_end_of(input logic [1:0] c);
        case (c)
            2'b10:   boot_end_of = 24'h0007fe;
            2'b01:   boot_end_of = 24'h001ffe;
            2'b00:   boot_end_of = 24'h003ffe;
            default: boot_end_of = 24'h000000;
        endcase
    endfunction : boot_end_of

    function automatic logic [23:0] sec_end_of(input logic [1:0] c);
        case (c)
            2'b10:   sec_end_of = 24'h001ffe;
            2'b01:   sec_end_of = 24'h003ffe;
            2'b00:   sec_end_of = 24'h007ffe;
            default: sec_end_of = 24'h000000;
        endcase
    endfunction : sec_end_of

    function automatic logic [10:0] boot_ram_of(input logic [1:0] c);
        case (c)
            2'b10:   boot_ram_of = 11'd128;
            2'b01:   boot_ram_of = 11'd256;
            2'b00:   boot_ram_of = 11'd1024;
            default: boot_ram_of = 11'd0;
        endcase
    endfunction : boot_ram_of

    // reading a byte applies fixed-value bits
    function automatic logic [7:0] view(input state_t x,
                                        input logic [2:0] i);
        view = x.bytes[i];
        if (i == 3'd1 && SMALL_VARIANT)
            view = `ERASED_BYTE;
        if (i == 3'd6)
            view = x.bytes[i] | `POR_RSVD_MASK;
    endfunction : view

    function automatic logic [2:0] addr_index(input logic [11:0] a);
        addr_index = a[4:2];
    endfunction : addr_index

    // ==========================================================
    // per-byte read view, built once for the bus path
    logic [7:0] byte_view [`NUM_BYTES];

    for (genvar g = 0; g < `NUM_BYTES; g++) begin : g_view
        assign byte_view[g] = view(s, 3'(g));
    end

    // ==========================================================
    // decoded image of the latched bytes
    mem_ctl_t dm;
    clk_ctl_t dc;
    logic [7:0] b_boot, b_sec, b_gen, b_src, b_osc, b_wdt;
    logic [12:0] sec_ram_raw;

    always_comb begin
        b_boot = view(s, 3'd0);
        b_sec  = view(s, 3'd1);
        b_gen  = view(s, 3'd2);
        b_src  = view(s, 3'd3);
        b_osc  = view(s, 3'd4);
        b_wdt  = view(s, 3'd5);
        dm = '0;
        dm.boot_write_protect   = ~b_boot[`BIT_BOOT_WP];
        dm.boot_present         = b_boot[2:1] != 2'b11;
        dm.boot_end             = boot_end_of(b_boot[2:1]);
        dm.boot_high_security   = dm.boot_present & ~b_boot[3];
        dm.boot_ram_bytes       = boot_ram_of(b_boot[7:6]);
        dm.secure_write_protect = ~b_sec[`BIT_SEC_WP];
        dm.secure_present       = b_sec[2:1] != 2'b11;
        dm.secure_end           = sec_end_of(b_sec[2:1]);
        dm.secure_high_security = dm.secure_present & ~b_sec[3];
        case (b_sec[7:6])
            2'b10:   sec_ram_raw = 13'd256;
            2'b01:   sec_ram_raw = 13'd200;
            2'b00:   sec_ram_raw = 13'd4096;
            default: sec_ram_raw = 13'd0;
        endcase
        dm.secure_ram_bytes = (sec_ram_raw == 13'd0) ? 13'd0 :
            13'(sec_ram_raw - {2'b00, boot_ram_of(b_boot[7:6])});
        dm.general_protected     = b_gen[2:1] != 2'b11;
        dm.general_high_security = ~b_gen[2];
        dm.general_write_protect = ~b_gen[`BIT_GEN_WP];
        dc = '0;
        dc.two_speed_startup  = b_src[`BIT_TWO_SPEED];
        dc.initial_osc_select = osc_src_t'(b_src[2:0]);
        dc.clock_switch_en    = ~b_osc[7];
        dc.fail_safe_en       = b_osc[7:6] == 2'b00;
        dc.pin_select_lock_policy = b_osc[`BIT_LOCK];
        dc.primary_osc_mode   = pri_mode_t'(b_osc[1:0]);
        // crystal modes own the second pin, so no clock output there
        dc.osc_pin_clock_out  = b_osc[`BIT_OSC_PIN] &
            (b_osc[1:0] != 2'b10) & (b_osc[1:0] != 2'b01);
        dc.watchdog_running   = b_wdt[`BIT_WDT_FORCE] |
                                software_watchdog_enable;
        dc.watchdog_window_mode = ~b_wdt[`BIT_WDT_WIN_OFF];
        dc.watchdog_prescale  = b_wdt[`BIT_WDT_PRE] ?
                                8'd128 : 8'd32;
    end

    // unprogrammed defaults, used while loading
    mem_ctl_t def_m;
    clk_ctl_t def_c;

    always_comb begin
        def_m = '0;
        def_m.boot_ram_bytes = 11'd0;
        def_c = '0;
        def_c.two_speed_startup  = 1'b1;
        def_c.initial_osc_select = osc_internal_fast_rc_post;
        def_c.pin_select_lock_policy = 1'b1;
        def_c.osc_pin_clock_out  = 1'b1;
        def_c.primary_osc_mode   = pri_off;
        def_c.watchdog_running   = 1'b1;
        def_c.watchdog_prescale  = 8'd128;
    end

    // ==========================================================
    // apb decode
    logic       acc;
    logic       mapped;
    logic [2:0] idx;

    always_comb begin
        acc    = psel & penable;
        idx    = addr_index(paddr);
        mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_STATUS);
    end

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0000_0000;
        case (s.st)
            st_load: begin
                // bytes stream in only during reset loading
                if (nv_valid) begin
                    next_s.bytes[nv_index] = nv_data;
                end
                next_s.mem = def_m;
                next_s.clk = def_c;
                if (nv_done) begin
                    next_s.st = st_run;
                end
            end
            st_run: begin
                next_s.mem        = dm;
                next_s.clk        = dc;
                next_s.wdt_forced = b_wdt[`BIT_WDT_FORCE];
                next_s.st         = st_lock;
            end
            st_lock: begin
                // only the software watchdog term may move after load;
                // the forced bit is a frozen copy, since table writes
                // may still change the byte behind it
                next_s.clk.watchdog_running = s.wdt_forced |
                    software_watchdog_enable;
            end
            default: next_s.st = st_load;
        endcase
        // table writes: each byte once per reset, ones to zeros
        if (acc & pwrite & mapped & (paddr < `OFS_STATUS) &
            ~s.written[idx]) begin
            next_s.bytes[idx]   = s.bytes[idx] & pwdata[7:0];
            next_s.written[idx] = 1'b1;
        end
        // read data taken in setup so the access phase shows a flop
        if (psel & ~penable & ~pwrite & mapped) begin
            if (paddr == `OFS_STATUS)
                next_s.rdata = {29'h0, s.st};
            else
                next_s.rdata = {24'h0, byte_view[idx]};
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.st      <= st_load;
            s.bytes   <= {`NUM_BYTES{`ERASED_BYTE}};
            s.written <= '0;
            s.wdt_forced <= 1'b0;
            s.mem     <= '0;
            s.clk     <= '0;
            s.rdata   <= 32'h0000_0000;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs; zero wait states, read data straight from its flop
    always_comb begin
        pready       = 1'b1;
        pslverr      = acc & ~mapped;
        prdata       = s.rdata;
        mem_ctl      = s.mem;
        clk_ctl      = s.clk;
        config_ready = s.st == st_lock;
    end

endmodule : device_config_fuse_decoder

// File: rtl/fuse_decoder_cfg.svh
`ifndef FUSE_DECODER_CFG_SVH
`define FUSE_DECODER_CFG_SVH

// ==========================================================
// register map (apb byte addresses)
`define OFS_BOOT      12'h000
`define OFS_SECURE    12'h004
`define OFS_GENERAL   12'h008
`define OFS_OSC_SRC   12'h00c
`define OFS_OSC       12'h010
`define OFS_WDT       12'h014
`define OFS_POR       12'h018
`define OFS_DEBUG     12'h01c
`define OFS_STATUS    12'h020
`define NUM_BYTES     8

// ==========================================================
// field positions
`define BIT_BOOT_WP    0
`define BIT_SEC_WP     0
`define BIT_GEN_WP     0
`define BIT_TWO_SPEED  7
`define BIT_LOCK       5
`define BIT_OSC_PIN    2
`define BIT_WDT_FORCE  7
`define BIT_WDT_WIN_OFF 6
`define BIT_WDT_PRE    4
`define POR_RSVD_MASK  8'he0
`define ERASED_BYTE    8'hff
`endif

// File: rtl/fuse_decoder_pkg.sv
package fuse_decoder_pkg;

    // boot segment end / secure segment end codes
    typedef enum logic [1:0] {
        seg_small = 2'b10, seg_mid = 2'b01, seg_large = 2'b00,
        seg_none = 2'b11
    } seg_size_t;

    typedef enum logic [2:0] {
        osc_internal_fast_rc       = 3'b000,
        osc_internal_fast_rc_pll   = 3'b001,
        osc_pri                    = 3'b010,
        osc_pri_pll                = 3'b011,
        osc_sec                    = 3'b100,
        osc_low_power_rc           = 3'b101,
        osc_internal_fast_rc_div16 = 3'b110,
        osc_internal_fast_rc_post  = 3'b111
    } osc_src_t;

    typedef enum logic [1:0] {
        pri_ext = 2'b00, pri_xt = 2'b01, pri_hs = 2'b10, pri_off = 2'b11
    } pri_mode_t;

    typedef enum logic [2:0] {
        st_load = 3'b001, st_run = 3'b010, st_lock = 3'b100
    } load_state_t;

    // memory protection controls
    typedef struct packed {
        logic        boot_write_protect;
        logic        boot_present;
        logic        boot_high_security;
        logic [23:0] boot_end;
        logic [10:0] boot_ram_bytes;
        logic        secure_write_protect;
        logic        secure_present;
        logic        secure_high_security;
        logic [23:0] secure_end;
        logic [12:0] secure_ram_bytes;
        logic        general_protected;
        logic        general_high_security;
        logic        general_write_protect;
    } mem_ctl_t;

    // clock and watchdog controls
    typedef struct packed {
        logic        two_speed_startup;
        osc_src_t    initial_osc_select;
        logic        clock_switch_en;
        logic        fail_safe_en;
        logic        pin_select_lock_policy;
        logic        osc_pin_clock_out;
        pri_mode_t   primary_osc_mode;
        logic        watchdog_running;
        logic        watchdog_window_mode;
        logic [7:0]  watchdog_prescale;
    } clk_ctl_t;

endpackage : fuse_decoder_pkg

// File: test/device_config_fuse_decoder_tb.sv
`timescale 1ns/1ps
module device_config_fuse_decoder_tb;
    import fuse_decoder_pkg::*;
    // ========================================================
    // signals and decode tables
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic        nv_valid, nv_done, sw_en, pready, pslverr, config_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, prdata_small, rd_small;
    logic [2:0]  nv_index;
    logic [7:0]  nv_data;
    logic [7:0]  b [8];
    mem_ctl_t    mem_ctl, mem_small;
    clk_ctl_t    clk_ctl;
    int          mismatches, n_tests;
    logic [23:0] bend [4] = '{24'h3ffe, 24'h1ffe, 24'h7fe, 24'h0};
    logic [23:0] send [4] = '{24'h7ffe, 24'h3ffe, 24'h1ffe, 24'h0};
    logic [12:0] bram [4] = '{13'd1024, 13'd256, 13'd128, 13'd0};
    logic [12:0] sram [4] = '{13'd4096, 13'd200, 13'd256, 13'd0};

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    device_config_fuse_decoder dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nv_valid(nv_valid),
        .nv_index(nv_index), .nv_data(nv_data), .nv_done(nv_done),
        .software_watchdog_enable(sw_en), .mem_ctl(mem_ctl),
        .clk_ctl(clk_ctl), .config_ready(config_ready)
    );

    // small variant on the same bus and load port
    device_config_fuse_decoder #(.SMALL_VARIANT(1'b1)) dut_small (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_small), .pready(), .pslverr(), .nv_valid(nv_valid),
        .nv_index(nv_index), .nv_data(nv_data), .nv_done(nv_done),
        .software_watchdog_enable(sw_en), .mem_ctl(mem_small),
        .clk_ctl(), .config_ready()
    );

    // ========================================================
    // tasks
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // one transfer; starts on a fresh edge so psel never toggles twice
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50)
            check("pready wait", 32'h0, 32'h1);
        rd = prdata;
        rd_small = prdata_small;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // reset, check defaults, load bytes, wait for ready
    task automatic start(input bit skip_wdt);
        int k;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        check("defaults", {config_ready, clk_ctl.primary_osc_mode,
            clk_ctl.initial_osc_select, clk_ctl.watchdog_prescale},
            {1'b0, pri_off, osc_internal_fast_rc_post, 8'h80});
        for (k = 0; k < 8; k++) begin
            @(posedge pclk);
            nv_valid <= !(skip_wdt && k == 5);
            nv_index <= k[2:0];
            nv_data <= b[k];
        end
        @(posedge pclk);
        nv_valid <= 1'b0;
        nv_done <= 1'b1;
        @(posedge pclk);
        nv_done <= 1'b0;
        for (k = 0; k < 20 && config_ready !== 1'b1; k++)
            @(posedge pclk);
        if (k == 20)
            check("ready wait", {31'h0, config_ready}, 32'h1);
        @(negedge pclk);
    endtask : start

    // ========================================================
    // eight configurations walk every code of each field
    initial begin
        logic [1:0] c, nc;
        {presetn, psel, penable, pwrite, nv_valid, nv_done, sw_en} = '0;
        {paddr, pwdata, nv_index, nv_data} = '0;
        for (int i = 0; i < 8; i++) begin
            c = i[1:0];
            nc = ~c;
            b[0] = {c, 2'b00, i[2:0], i[0]};
            b[1] = {nc, 2'b00, ~i[2:0], ~i[0]};
            b[2] = {5'h00, c, ~i[0]};
            b[3] = {i[0], 4'h0, i[2:0]};
            b[4] = {i[2:1], i[0], 2'b00, ~i[0], c};
            b[5] = {i[0], i[1], 1'b0, i[2], 4'h0};
            b[6] = 8'h00;
            b[7] = 8'hc3;
            sw_en <= i[2];
            start(1'b0);
            check("boot wp", mem_ctl.boot_write_protect, !i[0]);
            check("boot end", mem_ctl.boot_end, bend[c]);
            check("present", {mem_ctl.boot_present,
                mem_ctl.secure_present}, {c != 2'b11, nc != 2'b11});
            check("small sec", {mem_small.secure_present,
                mem_small.secure_write_protect,
                mem_small.secure_ram_bytes}, 15'h0);
            if (c != 2'b11)
                check("boot lvl", mem_ctl.boot_high_security, !i[2]);
            check("boot ram", mem_ctl.boot_ram_bytes, bram[c]);
            check("sec wp", mem_ctl.secure_write_protect, i[0]);
            check("sec end", mem_ctl.secure_end, send[nc]);
            if (nc != 2'b11)
                check("sec lvl", mem_ctl.secure_high_security, i[2]);
            check("sec ram", mem_ctl.secure_ram_bytes,
                (nc == 2'b11) ? 13'd0 : sram[nc] - bram[c]);
            check("gen prot", {mem_ctl.general_protected,
                mem_ctl.general_high_security}, {c != 2'b11, !c[1]});
            check("gen wp", mem_ctl.general_write_protect, i[0]);
            check("two spd", clk_ctl.two_speed_startup, i[0]);
            check("osc sel", clk_ctl.initial_osc_select, i[2:0]);
            check("switch", {clk_ctl.clock_switch_en,
                clk_ctl.fail_safe_en}, {!i[2], i[2:1] == 2'b00});
            check("lock", clk_ctl.pin_select_lock_policy, i[0]);
            if (c == 2'b00 || c == 2'b11)
                check("pin clk", clk_ctl.osc_pin_clock_out, !i[0]);
            check("pri mode", clk_ctl.primary_osc_mode, c);
            check("wdt run", clk_ctl.watchdog_running, i[0] | i[2]);
            check("wdt win", clk_ctl.watchdog_window_mode, !i[1]);
            check("wdt pre", clk_ctl.watchdog_prescale,
                i[2] ? 8'h80 : 8'h20);
            apb(1'b0, 12'h000, 32'h0);
            check("boot byte", rd, {24'h0, b[0]});
            $display("config test %0d done", i);
        end
        // watchdog byte left erased: one table write, then refusals
        sw_en <= 1'b0;
        start(1'b1);
        apb(1'b1, 12'h014, 32'h7f);
        apb(1'b1, 12'h014, 32'hff);
        apb(1'b1, 12'h014, 32'h00);
        apb(1'b0, 12'h014, 32'h0);
        check("wdt byte", rd, 32'h7f);
        check("wdt held", clk_ctl.watchdog_running, 1'b1);
        apb(1'b0, 12'h018, 32'h0);
        check("por byte", rd, 32'he0);
        apb(1'b0, 12'h004, 32'h0);
        check("small byte", rd_small, 32'hff);
        apb(1'b0, 12'h020, 32'h0);
        check("status", rd, 32'h4);
        apb(1'b0, 12'h024, 32'h0);
        check("unmapped", err, 1'b1);
        $display("write-once test done");
        print_verdict();
    end
endmodule : device_config_fuse_decoder_tb

// File: test/fuse_decoder_properties.sv
`timescale 1ns/1ps
module fuse_decoder_properties
    import fuse_decoder_pkg::*;
(
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // decoded side
    input wire logic        software_watchdog_enable,
    input wire mem_ctl_t    mem_ctl,
    input wire clk_ctl_t    clk_ctl,
    input wire logic        config_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================================
    // decode and bus properties; running is left out, it tracks software
    a_frozen_outputs: assert property (
        config_ready |=> $stable(mem_ctl) && $stable(clk_ctl.watchdog_prescale)
        && $stable(clk_ctl.initial_osc_select))
        else $error("decoded outputs moved after ready");
    a_ready_holds: assert property (config_ready |=> config_ready)
        else $error("ready dropped without reset");
    a_fail_safe_switch: assert property (
        clk_ctl.fail_safe_en |-> clk_ctl.clock_switch_en)
        else $error("monitor on while switching off");
    a_prescale_pair: assert property (
        config_ready |-> clk_ctl.watchdog_prescale inside {8'h80, 8'h20})
        else $error("prescale not 128 or 32");
    a_boot_ram_size: assert property (config_ready |->
        mem_ctl.boot_ram_bytes inside {11'd0, 11'd128, 11'd256, 11'd1024})
        else $error("boot ram size illegal");
    a_boot_end_absent: assert property (
        config_ready && !mem_ctl.boot_present |-> mem_ctl.boot_end == 24'h0)
        else $error("boot end set without segment");
    a_soft_watchdog: assert property (
        config_ready && software_watchdog_enable |=> clk_ctl.watchdog_running)
        else $error("software enable ignored");
    a_general_level: assert property (
        mem_ctl.general_high_security |-> mem_ctl.general_protected)
        else $error("high security without protection");
    a_unmapped_error: assert property (
        psel && penable && paddr > 12'h020 |-> pslverr && pready)
        else $error("unmapped access not refused");
    a_por_reserved: assert property (
        psel && penable && !pwrite && paddr == 12'h018
        |-> prdata[7:5] == 3'b111)
        else $error("reserved power-on bits not one");
    a_read_upper_zero: assert property (
        psel && penable && !pwrite && !pslverr |-> prdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    // main scenarios reached
    c_ready: cover property ($rose(config_ready));
    c_fail_safe: cover property (clk_ctl.fail_safe_en);
    c_refused: cover property (psel && penable && pslverr);
endmodule : fuse_decoder_properties

bind device_config_fuse_decoder fuse_decoder_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .software_watchdog_enable(software_watchdog_enable),
    .mem_ctl(mem_ctl), .clk_ctl(clk_ctl), .config_ready(config_ready)
);
